/* core/scale_float_command_interp.v */
// Floating point command interpreter with APB register access
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
`include "scale_float_cmd_defs.vh"

module scale_float_command_interp #(
  parameter ROT_FIELDS    = 9,
  parameter FILL_VALUES   = 10,
  parameter UPDATE_CYCLES = `SFC_UPDATE_CYCLES,
  parameter TICK_W        = 21
) (
  input  wire                    clk,
  input  wire                    rst_n,
  input  wire                    ce,
  input  wire                    psel,
  input  wire                    penable,
  input  wire                    pwrite,
  input  wire [7:0]              paddr,
  input  wire [31:0]             pwdata,
  output reg  [31:0]             prdata,
  output reg                     pready,
  output reg                     pslverr,
  input  wire [ROT_FIELDS*32-1:0] live_values,
  input  wire                    fill_option,
  output reg  [1:0]              cmd_ack,
  output reg  [7:0]              fp_ind,
  output reg  [31:0]             float_out,
  output reg                     message_show,
  output reg  [2:0]              message_event_index,
  output reg  [4:0]              message_char_count,
  output reg                     prompt_sequence_flag,
  output reg                     tare_enable,
  output reg                     keypad_enable,
  output reg  [31:0]             setup_config,
  output reg  [FILL_VALUES*32-1:0] comparator_limits,
  output reg  [9:0]              action_pulse
);

  // ****************************************************************
  // Command classes
  // ****************************************************************
  localparam C_NONE    = 4'h0;
  localparam C_ROT     = 4'h1;
  localparam C_STEP    = 4'h2;
  localparam C_ROT_CLR = 4'h3;
  localparam C_LIVE    = 4'h4;
  localparam C_ADD     = 4'h5;
  localparam C_MSG     = 4'h6;
  localparam C_SETUP   = 4'h7;
  localparam C_TARE    = 4'h8;
  localparam C_FILL_LD = 4'h9;
  localparam C_FILL_RP = 4'hA;
  localparam C_KEY     = 4'hB;
  localparam C_CMP_LD  = 4'hC;
  localparam C_KEYPAD  = 4'hD;
  localparam C_CMP_RP  = 4'hE;
  localparam C_CMP_AP  = 4'hF;

  localparam [31:0]       TICK_SPAN = UPDATE_CYCLES - 1;
  localparam [TICK_W-1:0] TICK_LAST = TICK_SPAN[TICK_W-1:0];

  function [3:0] cmd_class;
    input [15:0] c;
    begin
      if (c == `SFC_CMD_ROT_RUN)
        cmd_class = C_ROT;
      else if (c == `SFC_CMD_STEP_A || c == `SFC_CMD_STEP_B)
        cmd_class = C_STEP;
      else if (c == `SFC_CMD_ROT_CLR)
        cmd_class = C_ROT_CLR;
      else if (c >= `SFC_CMD_LIVE_LO && c <= `SFC_CMD_LIVE_HI)
        cmd_class = C_LIVE;
      else if (c >= `SFC_CMD_ADD_LO && c <= `SFC_CMD_ADD_HI)
        cmd_class = C_ADD;
      else if (c >= `SFC_CMD_MSG_CLR && c <= `SFC_CMD_MSG_SRC7)
        cmd_class = C_MSG;
      else if (c == `SFC_CMD_SETUP)
        cmd_class = C_SETUP;
      else if (c == `SFC_CMD_TARE_OFF || c == `SFC_CMD_TARE_ON)
        cmd_class = C_TARE;
      else if (c >= `SFC_CMD_FILL_LD && c < `SFC_CMD_FILL_RP)
        cmd_class = fill_option ? C_FILL_LD : C_NONE;
      else if (c >= `SFC_CMD_FILL_RP &&
               c < `SFC_CMD_FILL_RP + `SFC_BLOCK_LEN)
        cmd_class = C_FILL_RP;
      else if (c >= `SFC_CMD_KEY_LO && c < `SFC_CMD_KEY_FILL)
        cmd_class = C_KEY;
      else if (c >= `SFC_CMD_KEY_FILL && c <= `SFC_CMD_KEY_HI)
        cmd_class = fill_option ? C_KEY : C_NONE;
      else if (c >= `SFC_CMD_CMP_LD && c < `SFC_CMD_KEYPAD_OFF)
        cmd_class = C_CMP_LD;
      else if (c == `SFC_CMD_KEYPAD_OFF || c == `SFC_CMD_KEYPAD_ON)
        cmd_class = C_KEYPAD;
      else if (c >= `SFC_CMD_CMP_RP && c < `SFC_CMD_CMP_APPLY)
        cmd_class = C_CMP_RP;
      else if (c == `SFC_CMD_CMP_APPLY)
        cmd_class = C_CMP_AP;
      else
        cmd_class = C_NONE;
    end
  endfunction

  function [1:0] ack_next;
    input [1:0] a;
    begin
      ack_next = (a == 2'h3) ? 2'h1 : a + 2'h1;
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg  [15:0]       cmd;
  reg  [15:0]       last_cmd;
  reg  [31:0]       float_in;
  reg  [31:0]       cfg_pending;
  reg  [4:0]        msg_len;
  reg  [TICK_W-1:0] tick_cnt;
  reg               tick;
  reg  [3:0]        rot_field [0:ROT_FIELDS-1];
  reg  [3:0]        rot_len;
  reg  [3:0]        rot_pos;
  reg  [31:0]       fill_val  [0:FILL_VALUES-1];
  reg  [31:0]       cmp_pend  [0:FILL_VALUES-1];
  integer           i;

  wire [3:0]  cls     = cmd_class(cmd);
  wire        fresh   = (cmd != last_cmd);
  wire [15:0] off_lv  = cmd - `SFC_CMD_LIVE_LO;
  wire [15:0] off_add = cmd - `SFC_CMD_ADD_LO;
  wire [15:0] off_msg = cmd - `SFC_CMD_MSG_CLR;
  wire [15:0] off_fl  = cmd - `SFC_CMD_FILL_LD;
  wire [15:0] off_fr  = cmd - `SFC_CMD_FILL_RP;
  wire [15:0] off_key = cmd - `SFC_CMD_KEY_LO;
  wire [15:0] off_cl  = cmd - `SFC_CMD_CMP_LD;
  wire [15:0] off_cr  = cmd - `SFC_CMD_CMP_RP;
  wire [3:0]  cur_fld = rot_field[rot_pos];
  wire [3:0]  pos_inc = (rot_pos + 4'h1 >= rot_len) ? 4'h0
                                                     : rot_pos + 4'h1;
  wire        step_sw = (cmd == `SFC_CMD_STEP_A &&
                         last_cmd == `SFC_CMD_STEP_B) ||
                        (cmd == `SFC_CMD_STEP_B &&
                         last_cmd == `SFC_CMD_STEP_A);
  wire        apb_acc = psel & penable & pready;
  wire [31:0] status  = {4'h0, rot_len, 1'b0, tare_enable, keypad_enable,
                         message_show, prompt_sequence_flag,
                         message_event_index, fp_ind, 6'h00, cmd_ack};

  // ****************************************************************
  // Sequential logic
  // ****************************************************************
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata               <= `SFC_RST_WORD;
      pready               <= 1'b0;
      pslverr              <= 1'b0;
      cmd                  <= `SFC_RST_CMD;
      last_cmd             <= `SFC_RST_CMD;
      float_in             <= `SFC_RST_WORD;
      cfg_pending          <= `SFC_RST_WORD;
      setup_config         <= `SFC_RST_WORD;
      msg_len              <= `SFC_RST_MSG_LEN;
      message_char_count   <= 5'h00;
      tick_cnt             <= {TICK_W{1'b0}};
      tick                 <= 1'b0;
      rot_len              <= 4'h0;
      rot_pos              <= 4'h0;
      cmd_ack              <= `SFC_RST_ACK;
      fp_ind               <= `SFC_FPI_NO_DATA;
      float_out            <= `SFC_RST_WORD;
      message_show         <= 1'b0;
      message_event_index  <= 3'h0;
      prompt_sequence_flag <= 1'b0;
      tare_enable          <= 1'b1;
      keypad_enable        <= 1'b1;
      comparator_limits    <= {FILL_VALUES*32{1'b0}};
      action_pulse         <= 10'h000;
      for (i = 0; i < ROT_FIELDS; i = i + 1)
        rot_field[i] <= 4'h0;
      for (i = 0; i < FILL_VALUES; i = i + 1) begin
        fill_val[i] <= `SFC_RST_WORD;
        cmp_pend[i] <= `SFC_RST_WORD;
      end
    end else if (ce) begin
      action_pulse <= 10'h000;

      // APB slave: one wait-free access phase, pslverr on unmapped
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        case (paddr)
          `SFC_REG_CMD:       prdata <= {16'h0000, cmd};
          `SFC_REG_FLOAT_IN:  prdata <= float_in;
          `SFC_REG_FLOAT_OUT: prdata <= float_out;
          `SFC_REG_STATUS:    prdata <= status;
          `SFC_REG_CFG:       prdata <= cfg_pending;
          `SFC_REG_CFG_ACT:   prdata <= setup_config;
          `SFC_REG_MSG_LEN:   prdata <= {27'h0000000, msg_len};
          default: begin
            prdata  <= `SFC_RST_WORD;
            pslverr <= 1'b1;
          end
        endcase
      end
      if (apb_acc & pwrite) begin
        case (paddr)
          `SFC_REG_CMD:      cmd         <= pwdata[15:0];
          `SFC_REG_FLOAT_IN: float_in    <= pwdata;
          `SFC_REG_CFG:      cfg_pending <= pwdata;
          `SFC_REG_MSG_LEN:
            msg_len <= (pwdata > {27'h0000000, `SFC_MSG_MAX_CHARS})
                       ? `SFC_MSG_MAX_CHARS : pwdata[4:0];
          default: ;
        endcase
      end

      tick <= (tick_cnt == TICK_LAST);
      if (tick_cnt == TICK_LAST)
        tick_cnt <= {TICK_W{1'b0}};
      else
        tick_cnt <= tick_cnt + {{(TICK_W-1){1'b0}}, 1'b1};

      if (tick) begin
        last_cmd <= cmd;
        case (cls)
          C_ROT: begin
            cmd_ack <= 2'h0;
            if (rot_len == 4'h0) begin
              fp_ind    <= 8'h00;
              float_out <= live_values[31:0];
            end else begin
              fp_ind    <= {4'h0, cur_fld};
              float_out <= live_values[cur_fld*32 +: 32];
              rot_pos   <= pos_inc;
            end
          end
          C_STEP: begin
            cmd_ack <= 2'h0;
            if (rot_len != 4'h0 && step_sw) begin
              fp_ind    <= {4'h0, cur_fld};
              float_out <= live_values[cur_fld*32 +: 32];
              rot_pos   <= pos_inc;
            end
          end
          C_LIVE: begin
            fp_ind    <= {4'h0, off_lv[3:0]};
            float_out <= live_values[off_lv[3:0]*32 +: 32];
            if (fresh)
              cmd_ack <= ack_next(cmd_ack);
          end
          C_FILL_RP: begin
            fp_ind    <= `SFC_FPI_NO_DATA;
            float_out <= fill_val[off_fr[3:0]];
            if (fresh)
              cmd_ack <= ack_next(cmd_ack);
          end
          C_CMP_RP: begin
            fp_ind    <= `SFC_FPI_NO_DATA;
            float_out <= cmp_pend[off_cr[3:0]];
            if (fresh)
              cmd_ack <= ack_next(cmd_ack);
          end
          C_NONE: ;
          default: begin
            if (fresh) begin
              cmd_ack   <= ack_next(cmd_ack);
              fp_ind    <= `SFC_FPI_NO_DATA;
              float_out <= `SFC_RST_WORD;
              case (cls)
                C_ROT_CLR: begin
                  rot_len <= 4'h0;
                  rot_pos <= 4'h0;
                end
                C_ADD: begin
                  if (rot_len < ROT_FIELDS) begin
                    rot_field[rot_len] <= off_add[3:0];
                    rot_len            <= rot_len + 4'h1;
                  end
                end
                C_MSG: begin
                  if (off_msg[2:0] == 3'h0 && off_msg[3] == 1'b0) begin
                    message_show <= 1'b0;
                  end else begin
                    message_show        <= 1'b1;
                    message_char_count  <= msg_len;
                    message_event_index <= off_msg[2:0];
                    if (cmd == `SFC_CMD_PROMPT)
                      prompt_sequence_flag <= 1'b1;
                  end
                end
                C_SETUP: begin
                  setup_config    <= cfg_pending;
                  action_pulse[8] <= 1'b1;
                end
                C_TARE:   tare_enable   <= (cmd == `SFC_CMD_TARE_ON);
                C_KEYPAD: keypad_enable <= (cmd == `SFC_CMD_KEYPAD_ON);
                C_FILL_LD: begin
                  fill_val[off_fl[3:0]] <= float_in;
                  float_out             <= float_in;
                end
                C_KEY: begin
                  action_pulse[off_key[2:0]] <= 1'b1;
                end
                C_CMP_LD: begin
                  cmp_pend[off_cl[3:0]] <= float_in;
                  float_out             <= float_in;
                end
                C_CMP_AP: begin
                  for (i = 0; i < FILL_VALUES; i = i + 1)
                    comparator_limits[i*32 +: 32] <= cmp_pend[i];
                  action_pulse[9] <= 1'b1;
                end
                default: ;
              endcase
            end
          end
        endcase
      end
    end
  end

endmodule

/* shared/scale_float_cmd_defs.vh */
// Constants for the floating point command interpreter
`ifndef SCALE_FLOAT_CMD_DEFS_VH
`define SCALE_FLOAT_CMD_DEFS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SFC_REG_CMD        8'h00
`define SFC_REG_FLOAT_IN   8'h04
`define SFC_REG_FLOAT_OUT  8'h08
`define SFC_REG_STATUS     8'h0C
`define SFC_REG_CFG        8'h10
`define SFC_REG_CFG_ACT    8'h14
`define SFC_REG_MSG_LEN    8'h18

// ****************************************************************
// Status field positions
// ****************************************************************
`define SFC_ST_ACK_LO      0
`define SFC_ST_FPI_LO      8
`define SFC_ST_MSG_IDX_LO  16
`define SFC_ST_PROMPT      19
`define SFC_ST_MSG_SHOW    20
`define SFC_ST_KEYPAD_EN   21
`define SFC_ST_TARE_EN     22
`define SFC_ST_ROT_LEN_LO  24

// ****************************************************************
// Reset values
// ****************************************************************
`define SFC_RST_WORD       32'h00000000
`define SFC_RST_CMD        16'h0000
`define SFC_RST_ACK        2'h0
`define SFC_RST_MSG_LEN    5'h14

// ****************************************************************
// Command codes and indication codes
// ****************************************************************
`define SFC_CMD_ROT_RUN    16'h0000
`define SFC_CMD_STEP_A     16'h0001
`define SFC_CMD_STEP_B     16'h0002
`define SFC_CMD_ROT_CLR    16'h0003
`define SFC_CMD_LIVE_LO    16'h000A
`define SFC_CMD_LIVE_HI    16'h0012
`define SFC_CMD_ADD_LO     16'h0028
`define SFC_CMD_ADD_HI     16'h0030
`define SFC_CMD_MSG_CLR    16'h0050
`define SFC_CMD_MSG_LO     16'h0051
`define SFC_CMD_PROMPT     16'h0056
`define SFC_CMD_MSG_SRC7   16'h0057
`define SFC_CMD_SETUP      16'h00A0
`define SFC_CMD_TARE_OFF   16'h00A2
`define SFC_CMD_TARE_ON    16'h00A3
`define SFC_CMD_FILL_LD    16'h00AA
`define SFC_CMD_FILL_RP    16'h00B4
`define SFC_CMD_KEY_LO     16'h00C0
`define SFC_CMD_KEY_FILL   16'h00C2
`define SFC_CMD_KEY_HI     16'h00C7
`define SFC_CMD_CMP_LD     16'h00D2
`define SFC_CMD_KEYPAD_OFF 16'h00DC
`define SFC_CMD_KEYPAD_ON  16'h00DD
`define SFC_CMD_CMP_RP     16'h00DE
`define SFC_CMD_CMP_APPLY  16'h00E8
`define SFC_BLOCK_LEN      16'h000A
`define SFC_FPI_NO_DATA    8'h1E
`define SFC_MSG_MAX_CHARS  5'h14

// ****************************************************************
// Timing
// ****************************************************************
`define SFC_CLK_KHZ        25000
`define SFC_UPDATE_MS      60
`define SFC_UPDATE_CYCLES  (`SFC_CLK_KHZ * `SFC_UPDATE_MS)
`define SFC_PLC_POLL_MS    30

`endif

/* tb/scale_float_monitor.sv */
// Port assertions for the float command interpreter
`timescale 1ns/1ns
module scale_float_monitor (
  input wire        clk,
  input wire        rst_n,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [1:0]  cmd_ack,
  input wire [7:0]  fp_ind,
  input wire [31:0] float_out,
  input wire [2:0]  message_event_index,
  input wire [4:0]  message_char_count,
  input wire        prompt_sequence_flag,
  input wire [9:0]  action_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire bad_addr = paddr > 8'h18 || paddr[1:0] != 2'h0;
  // ****************************************************************
  // Bus phases
  // ****************************************************************
  sequence s_setup;
    psel && !penable && ce;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_setup_gives_ready: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_one_cycle: assert property (s_access |=> !pready)
    else $error("ready held too long");
  a_unmapped_refused: assert property (s_setup ##0 bad_addr |=>
    pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_accepted: assert property (s_setup ##0 !bad_addr |=>
    !pslverr)
    else $error("mapped access refused");
  a_ack_counts_up: assert property ($changed(cmd_ack) &&
    cmd_ack != 2'h0 && $past(cmd_ack) != 2'h0 |->
    cmd_ack == $past(cmd_ack) % 3 + 1)
    else $error("acknowledge count out of order");
  a_action_no_value: assert property (action_pulse != 10'h0 |->
    float_out == 32'h0 && fp_ind == 8'h1E)
    else $error("action left a value on the float output");
  a_pulse_one_cycle: assert property (action_pulse != 10'h0 |=>
    action_pulse == 10'h0)
    else $error("action pulse too long");
  a_prompt_stays_set: assert property (prompt_sequence_flag |=>
    prompt_sequence_flag)
    else $error("prompt flag dropped");
  a_prompt_index_six: assert property ($rose(prompt_sequence_flag) |->
    message_event_index == 3'h6)
    else $error("prompt index wrong");
  a_msg_len_capped: assert property (message_char_count <= 5'h14)
    else $error("message length above cap");
  a_output_holds: assert property ($changed(fp_ind) |=>
    $stable(fp_ind) [*6])
    else $error("indication changed between updates");
endmodule

bind scale_float_command_interp scale_float_monitor mon_u (
  .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmd_ack(cmd_ack), .fp_ind(fp_ind), .float_out(float_out),
  .message_event_index(message_event_index),
  .message_char_count(message_char_count),
  .prompt_sequence_flag(prompt_sequence_flag),
  .action_pulse(action_pulse)
);

/* tb/plc_model.sv */
// Controller-side model issuing bus transfers and commands
`timescale 1ns/1ns
`include "scale_float_cmd_defs.vh"
module plc_model #(
  parameter WAIT = 11
) (
  input  wire        clk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [7:0]  paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task xfer(input reg wr, input reg [7:0] a, input reg [31:0] d,
            output reg [31:0] q, output reg err);
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (!pready) @(posedge clk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
    end
  endtask
  task send(input reg [15:0] c, input reg [31:0] f);
    reg [31:0] q;
    reg        e;
    begin
      xfer(1'b1, `SFC_REG_FLOAT_IN, f, q, e);
      xfer(1'b1, `SFC_REG_CMD, {16'h0000, c}, q, e);
      repeat (WAIT) @(posedge clk);
    end
  endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the float command interpreter
`timescale 1ns/1ns
`include "scale_float_cmd_defs.vh"
module tb;
  localparam UPD = 8;
  reg          clk;
  reg          rst_n;
  reg          fill_option;
  reg  [287:0] live_values;
  reg  [9:0]   seen;
  reg  [1:0]   ea;
  reg  [31:0]  q;
  reg          e;
  reg  [7:0]   f0;
  reg  [7:0]   ef;
  integer      fail_count;
  integer      samples_checked;
  integer      k;
  integer      t;
  wire         psel, penable, pwrite, pready, pslverr;
  wire [7:0]   paddr, fp_ind;
  wire [31:0]  pwdata, prdata, float_out, setup_config;
  wire [1:0]   cmd_ack;
  wire         message_show, prompt_sequence_flag;
  wire         tare_enable, keypad_enable;
  wire [2:0]   message_event_index;
  wire [4:0]   message_char_count;
  wire [319:0] comparator_limits;
  wire [9:0]   action_pulse;

  scale_float_command_interp #(.UPDATE_CYCLES(UPD)) dut_u (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .live_values(live_values), .fill_option(fill_option),
    .cmd_ack(cmd_ack), .fp_ind(fp_ind), .float_out(float_out),
    .message_show(message_show),
    .message_event_index(message_event_index),
    .message_char_count(message_char_count),
    .prompt_sequence_flag(prompt_sequence_flag),
    .tare_enable(tare_enable), .keypad_enable(keypad_enable),
    .setup_config(setup_config), .comparator_limits(comparator_limits),
    .action_pulse(action_pulse));
  plc_model #(.WAIT(UPD + 3)) plc_u (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // ****************************************************************
  // Clock, pulse capture, checking helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      seen <= 10'h000;
    else
      seen <= seen | action_pulse;
  end
  task chk(input reg [63:0] got, input reg [63:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task acked;
    begin
      ea = ea % 3 + 1;
      chk(cmd_ack, ea);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    fail_count = fail_count + 1;
    report_and_stop;
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    fail_count = 0;
    samples_checked = 0;
    ea = 2'h0;
    rst_n = 1'b0;
    fill_option = 1'b0;
    for (k = 0; k < 9; k = k + 1)
      live_values[k*32+:32] = 32'h3F800000 + k;
    repeat (5) @(posedge clk);
    chk(fp_ind, 8'h1E);
    chk({tare_enable, keypad_enable}, 2'h3);
    rst_n <= 1'b1;
    plc_u.xfer(1'b0, `SFC_REG_MSG_LEN, 32'h0, q, e);
    chk(q, 32'h14);
    plc_u.xfer(1'b0, 8'h1C, 32'h0, q, e);
    chk({q, e}, 33'h1);
    plc_u.xfer(1'b1, `SFC_REG_MSG_LEN, 32'h19, q, e);
    plc_u.xfer(1'b0, `SFC_REG_MSG_LEN, 32'h0, q, e);
    chk(q, 32'h14);
    plc_u.xfer(1'b1, `SFC_REG_MSG_LEN, 32'h5, q, e);
    plc_u.xfer(1'b1, `SFC_REG_CFG, 32'hA5A50F0F, q, e);
    repeat (UPD + 3) @(posedge clk);
    chk(setup_config, 32'h0);
    chk({fp_ind, float_out}, {8'h00, 32'h3F800000});
    plc_u.send(`SFC_CMD_SETUP, 32'h0);
    acked;
    chk(setup_config, 32'hA5A50F0F);
    fill_option <= 1'b1;
    for (k = 0; k < 10; k = k + 1) begin
      plc_u.send(16'h00AA + k, 32'h41000000 + k);
      acked;
      chk(float_out, 32'h41000000 + k);
    end
    for (k = 0; k < 10; k = k + 1) begin
      plc_u.send(16'h00B4 + k, 32'h0);
      acked;
      chk(float_out, 32'h41000000 + k);
    end
    fill_option <= 1'b0;
    plc_u.send(16'h00AB, 32'h12345678);
    chk({cmd_ack, float_out}, {ea, 32'h41000009});
    plc_u.send(16'h00BE, 32'h0);
    chk(cmd_ack, ea);
    plc_u.send(16'h00C2, 32'h0);
    chk(cmd_ack, ea);
    fill_option <= 1'b1;
    for (k = 0; k < 8; k = k + 1) begin
      plc_u.send(16'h00C0 + k, 32'h3F000000);
      acked;
      chk({fp_ind, float_out}, {8'h1E, 32'h0});
    end
    for (k = 0; k < 10; k = k + 1) begin
      plc_u.send(16'h00D2 + k, 32'h42000000 + k);
      acked;
    end
    chk(comparator_limits[31:0], 32'h0);
    plc_u.send(16'h00E0, 32'h0);
    acked;
    chk(float_out, 32'h42000002);
    plc_u.send(`SFC_CMD_CMP_APPLY, 32'h0);
    acked;
    for (k = 0; k < 10; k = k + 1)
      chk(comparator_limits[k*32+:32], 32'h42000000 + k);
    for (k = 0; k < 4; k = k + 1) begin
      plc_u.send(k < 2 ? 16'h00A2 + k : 16'h00DA + k, 32'h0);
      acked;
      chk({tare_enable, keypad_enable}, {k != 0, k != 2});
    end
    for (k = 0; k < 7; k = k + 1) begin
      plc_u.send(16'h0051 + k, 32'h0);
      acked;
      chk({message_show, message_event_index}, {1'b1, k[2:0] + 3'h1});
      chk(message_char_count, 5'h5);
    end
    chk(prompt_sequence_flag, 1'b1);
    plc_u.send(`SFC_CMD_MSG_CLR, 32'h0);
    acked;
    chk(message_show, 1'b0);
    plc_u.send(16'h000B, 32'h0);
    acked;
    chk({fp_ind, float_out}, {8'h01, 32'h3F800001});
    live_values[63:32] <= 32'h44400000;
    repeat (UPD + 3) @(posedge clk);
    chk({fp_ind, float_out}, {8'h01, 32'h44400000});
    plc_u.send(16'h0012, 32'h0);
    acked;
    chk({fp_ind, float_out}, {8'h08, 32'h3F800008});
    plc_u.send(`SFC_CMD_ROT_CLR, 32'h0);
    acked;
    plc_u.send(16'h0028, 32'h0);
    acked;
    plc_u.send(16'h002E, 32'h0);
    acked;
    plc_u.send(`SFC_CMD_ROT_RUN, 32'h0);
    chk(cmd_ack, 2'h0);
    for (t = 0; t < 3; t = t + 1) begin
      f0 = fp_ind;
      ef = f0 == 8'h00 ? 8'h06 : 8'h00;
      k = 0;
      while (fp_ind === f0 && k < 3 * UPD) begin
        @(posedge clk);
        k = k + 1;
      end
      if (t > 0)
        chk(k, UPD);
      chk({fp_ind, float_out}, {ef, 32'h3F800000 + ef});
    end
    plc_u.send(`SFC_CMD_STEP_A, 32'h0);
    f0 = fp_ind;
    repeat (2 * UPD) @(posedge clk);
    chk(fp_ind, f0);
    plc_u.send(`SFC_CMD_STEP_B, 32'h0);
    chk(fp_ind, f0 == 8'h00 ? 8'h06 : 8'h00);
    chk(seen, 10'h3FF);
    report_and_stop;
  end
endmodule
